// ### rtl/timer8_event_divider_pwm.v
// One 8-bit timer channel: event counter, divider output and PWM modes.
// Assumes a classic Wishbone master on clk_sys; pins come in asynchronously.
// Functional notes
// RULE_01 - Event mode counts synchronised falling input edges
// RULE_02 - Event match: interrupt, clear counter, keep counting
// RULE_03 - Event input levels last two machine cycles
// RULE_04 - Software keeps flip-flop bit zero in event mode
// RULE_05 - Match value register takes writes immediately
// RULE_06 - Divider match: toggle flip-flop, clear, interrupt
// RULE_07 - Divider pin drives inverted flip-flop
// RULE_08 - Control write loads flip-flop; reset clears it
// RULE_09 - Stopped output holds; flip-flop changes later
// RULE_10 - Run bit three, flip-flop bit seven
// RULE_11 - PWM duty match toggles flip-flop, keeps counting
// RULE_12 - PWM overflow: toggle, clear, interrupt
// RULE_13 - PWM pin drives inverted flip-flop
// RULE_14 - Duty staged; transfers on interrupt or stopped
// RULE_15 - Duty read returns staged value
// RULE_16 - Software writes duty right after interrupt
// RULE_17 - Software sets port latch for timer output
// RULE_18 - Software stops PWM before stop mode
// RULE_19 - Prescaler taps select source clock
//
// Our own choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none
`include "timer8_map.vh"

module timer8_event_divider_pwm (
  input wire clk_sys,
  input wire sys_rst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  input wire event_in_pin,
  input wire low_freq_clock,
  output wire divider_out_pin_n,
  output wire pwm_out_pin_n,
  output wire pulse_gen_pin_n,
  output wire timer_match_irq
);

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // True when the low n prescaler bits are all ones
  function tap_hit;
    input [10:0] pre;
    input [3:0] n;
    reg [10:0] m;
    begin
      m = ~(11'h7ff << n);
      tap_hit = ((pre & m) == m);
    end
  endfunction
  // Word decode against a register index
  function reg_hit;
    input [7:0] adr;
    input [5:0] idx;
    begin
      reg_hit = (adr[7:2] == idx);
    end
  endfunction

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  reg ack_q; // Wishbone acknowledge
  reg [31:0] dat_q; // Registered read data
  reg [31:0] rd_d; // Read mux
  reg [8:0] ctrl_q; // Channel control register
  reg [7:0] match_q; // Match value register, unbuffered
  reg [7:0] duty_stage_q; // Duty staging stage
  reg [7:0] duty_act_q, duty_act_d; // Active duty compare and its next value
  reg [7:0] cnt_q, cnt_d; // Up-counter and its next value
  reg ff_q, ff_d; // Output flip-flop and its next value
  reg pin_q; // Registered inverted flip-flop
  reg [10:0] pre_q; // Free-running prescaler on clk_sys
  reg [2:0] low_div_q; // Divider for the slow clock
  reg [1:0] irq_stat_q, irq_mask_q; // Sticky interrupt status and its mask
  reg src_tick, match_evt, duty_evt; // Source tick, match or overflow, duty compare
  wire req, wr, wr_ctrl, wr_ctrl_hi, wr_match, wr_duty, wr_stat, wr_mask; // Bus decode
  wire run, slow_prescale_select, ev_fall, low_rise, low_tick; // Control and ticks
  wire [1:0] mode, irq_set; // Operating mode, interrupt events
  wire [2:0] clk_sel; // Source clock select
  wire [7:0] cnt_inc; // Counter plus one

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // RULE_03 - filter needs stable levels
  pin_edge_sync #(.RESET_LEVEL(1'b1)) u_event_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .pin_in(event_in_pin),
    .level(),
    .fall_pulse(ev_fall),
    .rise_pulse()
  );

  // Slow clock is sampled like any pin; only its rising edges matter
  pin_edge_sync #(.RESET_LEVEL(1'b0)) u_low_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .pin_in(low_freq_clock),
    .level(),
    .fall_pulse(),
    .rise_pulse(low_rise)
  );

  // ----------------------------------------
  // Wishbone slave
  // ----------------------------------------
  assign req = wb_cyc_i & wb_stb_i;
  // Writes commit on the edge where the master sees ack
  assign wr = req & wb_we_i & ack_q;
  assign wr_ctrl = wr & wb_sel_i[0] & reg_hit(wb_adr_i, `MAP_CTRL_IDX);
  assign wr_ctrl_hi = wr & wb_sel_i[1] & reg_hit(wb_adr_i, `MAP_CTRL_IDX);
  // RULE_05 - immediate match write
  assign wr_match = wr & wb_sel_i[0] & reg_hit(wb_adr_i, `MAP_MATCH_IDX);
  assign wr_duty = wr & wb_sel_i[0] & reg_hit(wb_adr_i, `MAP_DUTY_IDX);
  assign wr_stat = wr & wb_sel_i[0] & reg_hit(wb_adr_i, `MAP_IRQ_STAT_IDX);
  assign wr_mask = wr & wb_sel_i[0] & reg_hit(wb_adr_i, `MAP_IRQ_MASK_IDX);

  // Read mux; unmapped words read as zero and still acknowledge
  always @* begin
    rd_d = 32'h0000_0000;
    if (reg_hit(wb_adr_i, `MAP_CTRL_IDX)) begin
      rd_d[8:0] = {ctrl_q[8], ff_q, ctrl_q[6:3], 1'b0, ctrl_q[1:0]};
    end else if (reg_hit(wb_adr_i, `MAP_MATCH_IDX)) begin
      rd_d[7:0] = match_q;
    end else if (reg_hit(wb_adr_i, `MAP_DUTY_IDX)) begin
      // RULE_15 - read staging stage
      rd_d[7:0] = duty_stage_q;
    end else if (reg_hit(wb_adr_i, `MAP_COUNT_IDX)) begin
      rd_d[7:0] = cnt_q;
    end else if (reg_hit(wb_adr_i, `MAP_IRQ_STAT_IDX)) begin
      rd_d[1:0] = irq_stat_q;
    end else if (reg_hit(wb_adr_i, `MAP_IRQ_MASK_IDX)) begin
      rd_d[1:0] = irq_mask_q;
    end
  end

  // Ack one cycle after the request, dropped the cycle after
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req & ~ack_q;
      if (req & ~ack_q) begin
        dat_q <= rd_d;
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // ----------------------------------------
  // Control fields
  // ----------------------------------------
  // RULE_10 - run and flip-flop positions
  assign run = ctrl_q[`MAP_CTRL_RUN_BIT];
  assign mode = ctrl_q[`MAP_CTRL_MODE_MSB:`MAP_CTRL_MODE_LSB];
  assign clk_sel = ctrl_q[`MAP_CTRL_CLK_MSB:`MAP_CTRL_CLK_LSB];
  assign slow_prescale_select = ctrl_q[`MAP_CTRL_SLOW_BIT];

  // Control register, bit 7 is not stored here but in ff_q
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q <= `MAP_CTRL_RST;
      match_q <= `MAP_MATCH_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_q[6:0] <= {wb_dat_i[6:3], 1'b0, wb_dat_i[1:0]};
      end
      if (wr_ctrl_hi) begin
        ctrl_q[8] <= wb_dat_i[8];
      end
      if (wr_match) begin
        match_q <= wb_dat_i[7:0];
      end
    end
  end

  // ----------------------------------------
  // Prescaler and source clock
  // ----------------------------------------
  assign low_tick = low_rise & (low_div_q == `MAP_LOW_DIV_LAST);
  // Prescaler and slow divider; the slow divider steps on synchronised rises
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pre_q <= 11'h000;
      low_div_q <= 3'h0;
    end else begin
      pre_q <= pre_q + 11'h001;
      low_div_q <= low_div_q + {2'h0, low_rise};
    end
  end

  // RULE_19 - source clock tap select
  always @* begin
    src_tick = 1'b0;
    if (mode == `MAP_MODE_EVENT) begin
      // RULE_01 - count falling edges
      src_tick = ev_fall;
    end else begin
      case (clk_sel)
        `MAP_CLK_DIV2048: src_tick = slow_prescale_select ? low_tick :
                                     tap_hit(pre_q, `MAP_TAP_11);
        `MAP_CLK_DIV128: src_tick = tap_hit(pre_q, `MAP_TAP_7);
        `MAP_CLK_DIV32: src_tick = tap_hit(pre_q, `MAP_TAP_5);
        `MAP_CLK_DIV8: src_tick = tap_hit(pre_q, `MAP_TAP_3);
        // Slow-clock, clk/2 and full-clock sources exist only for PWM
        `MAP_CLK_LOW: src_tick = (mode == `MAP_MODE_PWM) & low_rise;
        `MAP_CLK_DIV2: src_tick = (mode == `MAP_MODE_PWM) & tap_hit(pre_q, `MAP_TAP_1);
        `MAP_CLK_FULL: src_tick = (mode == `MAP_MODE_PWM);
        default: src_tick = 1'b0;
      endcase
    end
  end

  // ----------------------------------------
  // Counter and output flip-flop
  // ----------------------------------------
  assign cnt_inc = cnt_q + 8'h01;

  // Next counter, flip-flop and events
  always @* begin
    cnt_d = cnt_q;
    ff_d = ff_q;
    match_evt = 1'b0;
    duty_evt = 1'b0;
    if (!run) begin
      // Stopped: counter cleared, flip-flop and pins hold unless a control write loads ff_q below
      cnt_d = 8'h00;
    end else if (src_tick) begin
      case (mode)
        `MAP_MODE_EVENT, `MAP_MODE_DIVIDER: begin
          // RULE_02 - match clears and interrupts
          if (cnt_inc == match_q) begin
            cnt_d = 8'h00;
            match_evt = 1'b1;
            // RULE_06 - divider toggles on match
            ff_d = (mode == `MAP_MODE_DIVIDER) ? ~ff_q : ff_q;
          end else begin
            cnt_d = cnt_inc;
          end
        end
        `MAP_MODE_PWM: begin
          if (cnt_q == `MAP_CNT_LAST) begin
            // RULE_12 - overflow toggles and clears
            cnt_d = 8'h00;
            ff_d = ~ff_q;
            match_evt = 1'b1;
          end else begin
            cnt_d = cnt_inc;
            // RULE_11 - duty compare toggles
            if (cnt_inc == duty_act_q) begin
              ff_d = ~ff_q;
              duty_evt = 1'b1;
            end
          end
        end
        default: cnt_d = cnt_q;
      endcase
    end
    // RULE_08 - software loads flip-flop
    // RULE_09 - only while already stopped
    // The write that stops the timer leaves ff_q alone, so the pin holds
    if (wr_ctrl & ~run) begin
      ff_d = wb_dat_i[`MAP_CTRL_FF_BIT];
    end
  end

  // RULE_14 - staged duty transfer
  // RULE_16 - coincident write loses to transfer
  always @* begin
    duty_act_d = duty_act_q;
    if (!run) begin
      duty_act_d = wr_duty ? wb_dat_i[7:0] : duty_stage_q;
    end else if (match_evt & (mode == `MAP_MODE_PWM)) begin
      duty_act_d = duty_stage_q;
    end
  end

  // Counter, flip-flop, duty and pin registers
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= 8'h00;
      ff_q <= 1'b0;
      pin_q <= 1'b1;
      duty_stage_q <= `MAP_DUTY_RST;
      duty_act_q <= `MAP_DUTY_RST;
    end else begin
      cnt_q <= cnt_d;
      ff_q <= ff_d;
      // RULE_07 - divider pin inverted
      // RULE_13 - PWM pin inverted
      pin_q <= ~ff_d;
      if (wr_duty) begin
        duty_stage_q <= wb_dat_i[7:0];
      end
      duty_act_q <= duty_act_d;
    end
  end

  // All timer pins share the flip-flop, hence the zero-flip-flop advice
  assign divider_out_pin_n = pin_q;
  assign pwm_out_pin_n = pin_q;
  assign pulse_gen_pin_n = pin_q;

  // ----------------------------------------
  // Interrupt status and mask
  // ----------------------------------------
  assign irq_set = {duty_evt, match_evt};

  // Set wins over a write-one clear in the same cycle
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      irq_stat_q <= 2'h0;
      irq_mask_q <= 2'h0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~(wr_stat ? wb_dat_i[1:0] : 2'h0)) | irq_set;
      if (wr_mask) begin
        irq_mask_q <= wb_dat_i[1:0];
      end
    end
  end

  assign timer_match_irq = |(irq_stat_q & irq_mask_q);
endmodule

`default_nettype wire

// ### rtl/timer8_map.vh
// Register map, field positions, reset values and codes of the 8-bit timer channel.
// Assumes a Wishbone word bus: byte address = word index * 4.
`ifndef TIMER8_MAP_VH
`define TIMER8_MAP_VH

// ----------------------------------------
// Word indices of the registers
// ----------------------------------------
`define MAP_CTRL_IDX 6'h00
`define MAP_MATCH_IDX 6'h01
`define MAP_DUTY_IDX 6'h02
`define MAP_COUNT_IDX 6'h03
`define MAP_IRQ_STAT_IDX 6'h04
`define MAP_IRQ_MASK_IDX 6'h05

// ----------------------------------------
// Channel control register fields
// ----------------------------------------
`define MAP_CTRL_MODE_LSB 0
`define MAP_CTRL_MODE_MSB 1
`define MAP_CTRL_RUN_BIT 3
`define MAP_CTRL_CLK_LSB 4
`define MAP_CTRL_CLK_MSB 6
`define MAP_CTRL_FF_BIT 7
`define MAP_CTRL_SLOW_BIT 8

// ----------------------------------------
// Operating modes
// ----------------------------------------
`define MAP_MODE_EVENT 2'h0
`define MAP_MODE_DIVIDER 2'h1
`define MAP_MODE_PWM 2'h2

// ----------------------------------------
// Source clock selects
// ----------------------------------------
`define MAP_CLK_DIV2048 3'h0
`define MAP_CLK_DIV128 3'h1
`define MAP_CLK_DIV32 3'h2
`define MAP_CLK_DIV8 3'h3
`define MAP_CLK_LOW 3'h4
`define MAP_CLK_DIV2 3'h5
`define MAP_CLK_FULL 3'h6

// Prescaler tap exponents
`define MAP_TAP_11 4'hb
`define MAP_TAP_7 4'h7
`define MAP_TAP_5 4'h5
`define MAP_TAP_3 4'h3
`define MAP_TAP_1 4'h1
`define MAP_LOW_DIV_LAST 3'h7

// ----------------------------------------
// Reset values and interrupt bits
// ----------------------------------------
`define MAP_CTRL_RST 9'h000
`define MAP_MATCH_RST 8'h00
`define MAP_DUTY_RST 8'h00
`define MAP_CNT_LAST 8'hff
`define MAP_IRQ_MATCH_BIT 0
`define MAP_IRQ_DUTY_BIT 1

`endif

// ### rtl/pin_edge_sync.v
// Three-flop input synchroniser with falling and rising edge pulses.
// Assumes the input is asynchronous to clk_sys and idles at RESET_LEVEL.
`timescale 1ns/100ps
`default_nettype none

module pin_edge_sync #(
  parameter RESET_LEVEL = 1'b1
) (
  input wire clk_sys,
  input wire sys_rst,
  input wire pin_in,
  output wire level,
  output wire fall_pulse,
  output wire rise_pulse
);

  reg s1_q; // First stage, read only by s2_q
  reg s2_q; // Second stage
  reg s3_q; // Third stage
  reg level_q; // Accepted level
  reg fall_q; // One-cycle falling pulse
  reg rise_q; // One-cycle rising pulse
  wire agree;

  // ----------------------------------------
  // Synchroniser and filter
  // ----------------------------------------
  assign agree = (s2_q == s3_q);

  // A change counts only once stages two and three agree
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      s1_q <= RESET_LEVEL;
      s2_q <= RESET_LEVEL;
      s3_q <= RESET_LEVEL;
      level_q <= RESET_LEVEL;
      fall_q <= 1'b0;
      rise_q <= 1'b0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      fall_q <= agree & level_q & ~s3_q;
      rise_q <= agree & ~level_q & s3_q;
      if (agree) begin
        level_q <= s3_q;
      end
    end
  end

  assign level = level_q;
  assign fall_pulse = fall_q;
  assign rise_pulse = rise_q;

endmodule

`default_nettype wire

// ### tb/timer8_checker_sva.sv
// Port checker of the 8-bit timer channel.
// Assumes classic Wishbone on clk_sys and one shared pin flip-flop.
`timescale 1ns/100ps
`default_nettype none
module timer8_checker (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic event_in_pin,
  input wire logic low_freq_clock,
  input wire logic divider_out_pin_n,
  input wire logic pwm_out_pin_n,
  input wire logic pulse_gen_pin_n,
  input wire logic timer_match_irq
);
  // ------------------------------
  // Shadow of written state
  // ------------------------------
  logic wr_lo; // Low byte write commits
  logic ctrl_wr; // Control write commits
  logic run_q; // Run bit as last written
  logic mask_zero_q; // No interrupt enabled
  assign wr_lo = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
  assign ctrl_wr = wr_lo && (wb_adr_i[7:2] == 6'h00);
  // Follows commits only, so it moves on the same edge as the design
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      run_q <= 1'b0;
      mask_zero_q <= 1'b1;
    end else begin
      if (ctrl_wr) begin
        run_q <= wb_dat_i[3];
      end
      if (wr_lo && (wb_adr_i[7:2] == 6'h05)) begin
        mask_zero_q <= (wb_dat_i[1:0] == 2'h0);
      end
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // ------------------------------
  // Properties
  // ------------------------------
  AST_ACK_ONE: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack one cycle after request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_ACK_CAUSE: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  AST_PINS_SAME: assert property (
    pwm_out_pin_n == divider_out_pin_n && pulse_gen_pin_n == divider_out_pin_n)
    else $error("output pins differ");
  AST_IRQ_MASKED: assert property (mask_zero_q |-> !timer_match_irq)
    else $error("interrupt high while masked");
  AST_HOLD_STOP: assert property (
    !run_q && !ctrl_wr |=> $stable(divider_out_pin_n))
    else $error("pin moved while stopped");
  AST_FF_LOAD: assert property (
    ctrl_wr && !run_q |=> divider_out_pin_n == !$past(wb_dat_i[7]))
    else $error("flip-flop not loaded from control write");
  AST_READ_UPPER: assert property (
    wb_ack_o && !wb_we_i |-> wb_dat_o[31:9] == 23'h00_0000)
    else $error("upper read bits not zero");
  COV_IRQ: cover property ($rose(timer_match_irq));
  COV_TOGGLE: cover property (run_q && $changed(divider_out_pin_n));
  COV_LOAD: cover property (ctrl_wr && !run_q);
endmodule
bind timer8_event_divider_pwm timer8_checker i_timer8_checker (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .event_in_pin(event_in_pin),
  .low_freq_clock(low_freq_clock), .divider_out_pin_n(divider_out_pin_n),
  .pwm_out_pin_n(pwm_out_pin_n), .pulse_gen_pin_n(pulse_gen_pin_n),
  .timer_match_irq(timer_match_irq)
);
`default_nettype wire

// ### tb/event_pin_model.sv
// Far side of the timer: event source and slow clock source.
// Assumes clk_sys runs; edges are launched just after a rising edge.
`timescale 1ns/100ps
`default_nettype none
module event_pin_model (
  input wire logic clk_sys,
  output logic event_in_pin,
  output logic low_freq_clock
);
  // Event line idles high, slow clock starts low
  initial begin
    event_in_pin = 1'b1;
    low_freq_clock = 1'b0;
  end
  // Slow clock runs free, one toggle every 16 system clocks
  always begin
    repeat (16) @(posedge clk_sys);
    low_freq_clock <= ~low_freq_clock;
  end
  // minimum level width
  // Six clocks per level leaves margin over the synchroniser
  task automatic send_falls(input int count);
    repeat (count) begin
      @(posedge clk_sys);
      event_in_pin <= 1'b0;
      repeat (6) @(posedge clk_sys);
      event_in_pin <= 1'b1;
      repeat (6) @(posedge clk_sys);
    end
  endtask
endmodule
`default_nettype wire

// ### tb/test_timer8_event_divider_pwm.sv
// Self-checking bench of the 8-bit timer channel.
// Assumes the pin model beside it and the bound port checker.
`timescale 1ns/100ps
`default_nettype none
`include "timer8_map.vh"
module test_timer8_event_divider_pwm;
  localparam logic [7:0] A_CTRL = {`MAP_CTRL_IDX, 2'b00};
  localparam logic [7:0] A_MATCH = {`MAP_MATCH_IDX, 2'b00};
  localparam logic [7:0] A_DUTY = {`MAP_DUTY_IDX, 2'b00};
  localparam logic [7:0] A_CNT = {`MAP_COUNT_IDX, 2'b00};
  localparam logic [7:0] A_STAT = {`MAP_IRQ_STAT_IDX, 2'b00};
  localparam logic [7:0] A_MASK = {`MAP_IRQ_MASK_IDX, 2'b00};
  logic clk_sys, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, rd;
  wire logic [31:0] wb_dat_o;
  wire logic wb_ack_o, event_in_pin, low_freq_clock, timer_match_irq;
  wire logic divider_out_pin_n, pwm_out_pin_n, pulse_gen_pin_n;
  int err_count, n_checks, n;
  logic p;
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  timer8_event_divider_pwm i_timer8_event_divider_pwm (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .event_in_pin(event_in_pin), .low_freq_clock(low_freq_clock),
    .divider_out_pin_n(divider_out_pin_n), .pwm_out_pin_n(pwm_out_pin_n),
    .pulse_gen_pin_n(pulse_gen_pin_n), .timer_match_irq(timer_match_irq));
  event_pin_model i_event_pin_model (.clk_sys(clk_sys), .event_in_pin(event_in_pin),
    .low_freq_clock(low_freq_clock));
  // ------------------------------
  // Shared tasks
  // ------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // One classic cycle; ack sampled on rising edges, released on the ack edge
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (wb_ack_o !== 1'b1 && i < 16);
    if (i >= 16) begin
      err_count++;
      final_report();
    end
    // Same edge that sees ack: take the data, then release
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  // Cycles until the pin shows lvl, counted at falling clock edges
  task automatic wait_pin(input logic lvl);
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (divider_out_pin_n !== lvl && n < 600);
    if (n >= 600) begin
      err_count++;
      final_report();
    end
  endtask
  // port latch taken as set
  // All three pins and the interrupt line together, once settled
  task automatic probe(input logic [1:0] exp);
    @(negedge clk_sys);
    check({pwm_out_pin_n, pulse_gen_pin_n, divider_out_pin_n, timer_match_irq},
      {exp[1], exp[1], exp});
  endtask
  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    sys_rst = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0000_0000;
    err_count = 0;
    n_checks = 0;
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    // All words and an unmapped one read zero
    for (int k = 0; k < 7; k++) begin
      xfer(1'b0, (k < 6) ? 8'(k * 4) : 8'h40, 32'h0000_0000);
      check(rd, 32'h0000_0000);
    end
    probe(2'b10);
    xfer(1'b1, A_CTRL, 32'h0000_0080);
    probe(2'b00);
    xfer(1'b1, A_CTRL, 32'h0000_0000);
    probe(2'b10);
    // Event counting up to a match of three
    xfer(1'b1, A_MATCH, 32'h0000_0003);
    xfer(1'b1, A_MASK, 32'h0000_0001);
    xfer(1'b1, A_CTRL, 32'h0000_0008);
    i_event_pin_model.send_falls(2);
    xfer(1'b0, A_CNT, 32'h0000_0000);
    check(rd, 32'h0000_0002);
    probe(2'b10);
    i_event_pin_model.send_falls(1);
    xfer(1'b0, A_CNT, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    probe(2'b11);
    xfer(1'b1, A_MASK, 32'h0000_0000);
    probe(2'b10);
    xfer(1'b1, A_MASK, 32'h0000_0001);
    probe(2'b11);
    xfer(1'b1, A_STAT, 32'h0000_0001);
    probe(2'b10);
    // A new match value acts on the very next event
    xfer(1'b1, A_MATCH, 32'h0000_0001);
    i_event_pin_model.send_falls(1);
    probe(2'b11);
    xfer(1'b1, A_STAT, 32'h0000_0001);
    // Divider at clk/8 with match two: sixteen cycles per level
    xfer(1'b1, A_MATCH, 32'h0000_0002);
    xfer(1'b1, A_CTRL, 32'h0000_0039);
    wait_pin(1'b1);
    wait_pin(1'b0);
    wait_pin(1'b1);
    check(32'(n), 32'h0000_0010);
    wait_pin(1'b0);
    check(32'(n), 32'h0000_0010);
    xfer(1'b1, A_CTRL, 32'h0000_00b1);
    @(negedge clk_sys);
    p = divider_out_pin_n;
    repeat (100) @(negedge clk_sys);
    check(divider_out_pin_n, p);
    // PWM at full clock, duty 0x40, period 256
    xfer(1'b1, A_DUTY, 32'h0000_0040);
    xfer(1'b0, A_DUTY, 32'h0000_0000);
    check(rd, 32'h0000_0040);
    xfer(1'b1, A_CTRL, 32'h0000_006a);
    wait_pin(1'b0);
    wait_pin(1'b1);
    check(32'(n), 32'h0000_00c0);
    wait_pin(1'b0);
    check(32'(n), 32'h0000_0040);
    xfer(1'b1, A_DUTY, 32'h0000_0080);
    xfer(1'b0, A_DUTY, 32'h0000_0000);
    check(rd, 32'h0000_0080);
    wait_pin(1'b0);
    wait_pin(1'b1);
    wait_pin(1'b0);
    check(32'(n), 32'h0000_0080);
    xfer(1'b0, A_STAT, 32'h0000_0000);
    check(rd, 32'h0000_0003);
    // Same duty at clk/2: the high phase doubles to 256 cycles
    xfer(1'b1, A_CTRL, 32'h0000_005a);
    wait_pin(1'b1);
    wait_pin(1'b0);
    check(32'(n), 32'h0000_0100);
    // Stop, hold, then steer the pin from a later write
    xfer(1'b1, A_CTRL, 32'h0000_0062);
    xfer(1'b1, A_STAT, 32'h0000_0003);
    @(negedge clk_sys);
    p = divider_out_pin_n;
    repeat (300) @(negedge clk_sys);
    check(divider_out_pin_n, p);
    xfer(1'b1, A_CTRL, 32'h0000_00e2);
    probe(2'b00);
    xfer(1'b0, A_CTRL, 32'h0000_0000);
    check(rd, 32'h0000_00e2);
    xfer(1'b1, A_CTRL, 32'h0000_0062);
    probe(2'b10);
    final_report();
  end
endmodule
`default_nettype wire
